// ---- design/ics_core_timing.sv ----
// instruction cycle sequencing, fetch/execute pipeline and status register
// ****************************************************************
// ****************************************************************
module ics_core_timing #(
	parameter int PC_W = 13,
	parameter int IW = 14
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ics_pkg::APB_AW-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic [PC_W-1:0] pm_addr,
	input wire logic [IW-1:0] pm_rdata,
	output logic [IW-1:0] ir,
	output logic ir_valid,
	output logic [3:0] phase_oh,
	input wire ics_pkg::ics_exec_t ex,
	input wire logic [PC_W-1:0] jump_target,
	output ics_pkg::ics_dmem_t dm,
	input wire logic [7:0] dm_rdata,
	output logic [7:0] operand,
	output logic [7:0] status,
	input wire logic timeout_set,
	input wire logic timeout_clr,
	input wire logic pwrdn_set,
	input wire logic pwrdn_clr
);
	import ics_pkg::*;

	typedef struct packed {
		logic [PC_W-1:0] pc;
		logic [PC_W-1:0] pm_addr;
		logic [IW-1:0] fetch;
		logic fetch_valid;
		logic [IW-1:0] ir;
		logic ir_valid;
		ics_dmem_t dm;
		logic [7:0] operand;
		logic [7:0] status;
		logic run;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} ics_core_state_t;

	ics_core_state_t st_q;
	ics_core_state_t st_d;
	ics_phase_t phase_q;
	logic [3:0] phase_oh_q;
	logic adv;

	// ****************************************************************
	// helpers
	// ****************************************************************
	function automatic logic is_status(input logic [7:0] a);
		return (a == STATUS_ADDR_BANK0) || (a == STATUS_ADDR_BANK1);
	endfunction

	// carry flags read as not-borrow when subtracting
	function automatic logic carry_flag(input logic raw, input logic sub);
		return sub ? ~raw : raw;
	endfunction

	// next status value after an executed instruction
	function automatic logic [7:0] status_exec(input logic [7:0] s, input ics_exec_t e);
		logic [7:0] n;
		logic aff;
		n = s;
		aff = e.aff_z | e.aff_dc | e.aff_c;
		if (e.dest_we && is_status(e.dest_addr)) begin
			n = (n & ~STATUS_UPPER_MASK) | (e.result & STATUS_UPPER_MASK);
			if (!aff) begin
				n = (n & ~STATUS_FLAG_MASK) | (e.result & STATUS_FLAG_MASK);
			end
		end
		if (e.aff_z) begin
			n[ST_ZERO] = (e.result == 8'h00);
		end
		if (e.aff_dc) begin
			n[ST_DCARRY] = carry_flag(e.dcarry_raw, e.subtract);
		end
		if (e.aff_c) begin
			n[ST_CARRY] = carry_flag(e.carry_raw, e.subtract);
		end
		return n;
	endfunction

	// ****************************************************************
	// phase generator
	// ****************************************************************
	// the whole pipeline stands still while software has stopped it
	assign adv = ce & st_q.run;

	ics_phase_gen u_phase (
		.clk(clk),
		.resetn(resetn),
		.en(adv),
		.phase_q(phase_q),
		.phase_oh_q(phase_oh_q)
	);

	// ****************************************************************
	// next state
	// ****************************************************************
	always_comb begin
		st_d = st_q;
		if (adv) begin
			// strobes end with their phase; a stalled phase keeps them, so a held read stays valid
			st_d.dm.rd = 1'b0;
			st_d.dm.we = 1'b0;
			case (phase_q)
				PH_FOUR: begin
					// entering phase one
					st_d.pc = st_q.pc + 1'b1;
					st_d.pm_addr = st_q.pc;
					st_d.ir = st_q.fetch;
					st_d.ir_valid = st_q.fetch_valid;
				end
				PH_ONE: begin
					st_d.dm.rd = st_q.ir_valid;
					st_d.dm.raddr = ex.op_addr;
				end
				PH_TWO: begin
					// status is read from here, not from data memory
					st_d.operand = is_status(st_q.dm.raddr) ? st_q.status : dm_rdata;
				end
				PH_THREE: begin
					// entering phase four
					st_d.fetch = pm_rdata;
					st_d.fetch_valid = 1'b1;
					if (st_q.ir_valid) begin
						st_d.status = status_exec(st_q.status, ex);
						st_d.dm.we = ex.dest_we && !is_status(ex.dest_addr);
						st_d.dm.waddr = ex.dest_addr;
						st_d.dm.wdata = ex.result;
						if (ex.jump) begin
							// prefetched word is stale: it becomes a bubble
							st_d.pc = jump_target;
							st_d.fetch_valid = 1'b0;
						end
					end
				end
				default: st_d.fetch_valid = st_q.fetch_valid;
			endcase
		end
		if (ce) begin
			// software writes never reach these two bits
			if (timeout_clr) st_d.status[ST_TIMEOUT] = 1'b0;
			if (timeout_set) st_d.status[ST_TIMEOUT] = 1'b1;
			if (pwrdn_clr) st_d.status[ST_PWRDN] = 1'b0;
			if (pwrdn_set) st_d.status[ST_PWRDN] = 1'b1;
			// apb slave: one wait-free access phase
			st_d.pready = psel && !penable && !st_q.pready;
			if (psel && !penable && !st_q.pready) begin
				st_d.pslverr = 1'b0;
				case (paddr)
					APB_CTRL: st_d.prdata = {31'h0, st_q.run};
					APB_STATUS: st_d.prdata = {21'h0, phase_q, st_q.ir_valid, st_q.status};
					APB_PC: st_d.prdata = 32'(st_q.pc);
					APB_IR: st_d.prdata = 32'(st_q.ir);
					default: begin
						st_d.prdata = 32'h0;
						st_d.pslverr = 1'b1;
					end
				endcase
			end
			if (psel && penable && st_q.pready && pwrite && paddr == APB_CTRL) begin
				st_d.run = pwdata[CTRL_RUN_BIT];
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			st_q <= '0;
			st_q.status <= STATUS_RESET;
			st_q.run <= CTRL_RUN_RESET;
		end else begin
			st_q <= st_d;
		end
	end

	assign prdata = st_q.prdata;
	assign pready = st_q.pready;
	assign pslverr = st_q.pslverr;
	assign pm_addr = st_q.pm_addr;
	assign ir = st_q.ir;
	assign ir_valid = st_q.ir_valid;
	assign phase_oh = phase_oh_q;
	assign dm = st_q.dm;
	assign operand = st_q.operand;
	assign status = st_q.status;

	// ****************************************************************
	// checks
	// ****************************************************************
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!resetn);

	logic no_dev_evt;
	assign no_dev_evt = !timeout_set && !timeout_clr && !pwrdn_set && !pwrdn_clr;

	property p_pc_inc;
		adv && phase_q == PH_FOUR |=> st_q.pc == PC_W'($past(st_q.pc) + 1'b1);
	endproperty
	a_pc_inc: assert property (p_pc_inc) else $error("pc did not step at phase one");

	property p_fetch;
		adv && phase_q == PH_THREE |=> st_q.fetch == $past(pm_rdata) && phase_q == PH_FOUR;
	endproperty
	a_fetch: assert property (p_fetch) else $error("fetch not latched into phase four");

	property p_ir_load;
		adv && phase_q == PH_FOUR |=> st_q.ir == $past(st_q.fetch) && phase_oh_q == 4'h1;
	endproperty
	a_ir_load: assert property (p_ir_load) else $error("ir not loaded at phase one");

	property p_jump_bubble;
		adv && phase_q == PH_THREE && st_q.ir_valid && ex.jump ##1 adv |=> !st_q.ir_valid;
	endproperty
	a_jump_bubble: assert property (p_jump_bubble) else $error("jump did not discard");

	property p_dm_phases;
		(st_q.dm.rd |-> phase_q == PH_TWO) and (st_q.dm.we |-> phase_q == PH_FOUR);
	endproperty
	a_dm_phases: assert property (p_dm_phases) else $error("data access in wrong phase");

	property p_status_no_dm;
		st_q.dm.we |-> !is_status(st_q.dm.waddr);
	endproperty
	a_status_no_dm: assert property (p_status_no_dm) else $error("status write leaked");

	property p_to_pd_hold;
		ce && no_dev_evt |=> st_q.status[4:3] == $past(st_q.status[4:3]);
	endproperty
	a_to_pd_hold: assert property (p_to_pd_hold) else $error("timeout/powerdown moved");

	property p_flag_override;
		adv && phase_q == PH_THREE && st_q.ir_valid && ex.dest_we && is_status(ex.dest_addr)
			&& ex.aff_z |=> st_q.status[ST_ZERO] == ($past(ex.result) == 8'h00);
	endproperty
	a_flag_override: assert property (p_flag_override) else $error("zero flag wrong");

	property p_clear_file;
		adv && phase_q == PH_THREE && st_q.ir_valid && ex.dest_we && is_status(ex.dest_addr)
			&& ex.result == 8'h00 && ex.aff_z && !ex.aff_dc && !ex.aff_c && no_dev_evt
			|=> st_q.status == (($past(st_q.status) & 8'h1b) | 8'h04);
	endproperty
	a_clear_file: assert property (p_clear_file) else $error("clear-file result wrong");

	property p_sub_borrow;
		adv && phase_q == PH_THREE && st_q.ir_valid && ex.aff_c && ex.subtract
			|=> st_q.status[ST_CARRY] == !$past(ex.carry_raw);
	endproperty
	a_sub_borrow: assert property (p_sub_borrow) else $error("borrow polarity wrong");

	property p_mirror_read;
		adv && phase_q == PH_TWO && is_status(st_q.dm.raddr) |=> operand == $past(st_q.status);
	endproperty
	a_mirror_read: assert property (p_mirror_read) else $error("status read wrong");

	property p_operand;
		adv && phase_q == PH_TWO && st_q.dm.rd && !is_status(st_q.dm.raddr)
			|=> operand == $past(dm_rdata);
	endproperty
	a_operand: assert property (p_operand) else $error("operand not taken in phase two");

	// a low enable must leave every pipeline and status register untouched
	property p_ce_freeze;
		!ce |=> st_q == $past(st_q);
	endproperty
	a_ce_freeze: assert property (p_ce_freeze) else $error("state moved while disabled");

	property p_plain_write;
		adv && phase_q == PH_THREE && st_q.ir_valid && ex.dest_we && is_status(ex.dest_addr)
			&& !ex.aff_z && !ex.aff_dc && !ex.aff_c
			|=> (st_q.status & 8'he7) == ($past(ex.result) & 8'he7);
	endproperty
	a_plain_write: assert property (p_plain_write) else $error("flagless write lost");

	c_jump: cover property (adv && phase_q == PH_THREE && st_q.ir_valid && ex.jump);
	c_status_wr: cover property (adv && phase_q == PH_THREE && st_q.ir_valid && ex.dest_we
		&& is_status(ex.dest_addr));
	c_dm_wr: cover property (st_q.dm.we);
	c_apb_err: cover property (pready && pslverr);

endmodule

// ---- design/ics_phase_gen.sv ----
// divide-by-four quadrature phase generator
module ics_phase_gen (
	input wire logic clk,
	input wire logic resetn,
	input wire logic en,
	output ics_pkg::ics_phase_t phase_q,
	output logic [3:0] phase_oh_q
);
	import ics_pkg::*;

	typedef struct packed {
		ics_phase_t ph;
		logic [3:0] oh;
	} ics_pg_state_t;

	ics_pg_state_t st_q;
	ics_pg_state_t st_d;

	always_comb begin
		st_d = st_q;
		if (en) begin
			case (st_q.ph)
				PH_ONE: st_d.ph = PH_TWO;
				PH_TWO: st_d.ph = PH_THREE;
				PH_THREE: st_d.ph = PH_FOUR;
				PH_FOUR: st_d.ph = PH_ONE;
				default: st_d.ph = PH_ONE;
			endcase
			st_d.oh = 4'h1 << st_d.ph;
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			st_q <= '{ph: PHASE_RESET, oh: PHASE_OH_RESET};
		end else begin
			st_q <= st_d;
		end
	end

	assign phase_q = st_q.ph;
	assign phase_oh_q = st_q.oh;

	// ****************************************************************
	// checks
	// ****************************************************************
	property p_phase_step;
		@(posedge clk) disable iff (!resetn)
		en && st_q.ph == PH_FOUR |=> st_q.ph == PH_ONE ##0 $onehot(st_q.oh) ##0 st_q.oh[0];
	endproperty
	a_phase_step: assert property (p_phase_step) else $error("phase four not followed by one");

endmodule

// ---- design/ics_pkg.sv ----
// shared constants and types of the instruction cycle and status block
package ics_pkg;

	// ****************************************************************
	// quadrature phases
	// ****************************************************************
	typedef enum logic [1:0] {
		PH_ONE = 2'b00,
		PH_TWO = 2'b01,
		PH_THREE = 2'b10,
		PH_FOUR = 2'b11
	} ics_phase_t;

	localparam int PHASES_PER_CYCLE = 4;
	localparam ics_phase_t PHASE_RESET = PH_FOUR;
	localparam logic [3:0] PHASE_OH_RESET = 4'h8;

	// ****************************************************************
	// status register
	// ****************************************************************
	localparam logic [7:0] STATUS_ADDR_BANK0 = 8'h03;
	localparam logic [7:0] STATUS_ADDR_BANK1 = 8'h83;
	localparam int ST_IND_BANK = 7;
	localparam int ST_BANK_HI = 6;
	localparam int ST_BANK_LO = 5;
	localparam int ST_TIMEOUT = 4;
	localparam int ST_PWRDN = 3;
	localparam int ST_ZERO = 2;
	localparam int ST_DCARRY = 1;
	localparam int ST_CARRY = 0;
	localparam logic [7:0] STATUS_RESET = 8'h18;
	localparam logic [7:0] STATUS_UPPER_MASK = 8'he0;
	localparam logic [7:0] STATUS_FLAG_MASK = 8'h07;

	// ****************************************************************
	// apb register map
	// ****************************************************************
	localparam int APB_AW = 8;
	localparam logic [7:0] APB_CTRL = 8'h00;
	localparam logic [7:0] APB_STATUS = 8'h04;
	localparam logic [7:0] APB_PC = 8'h08;
	localparam logic [7:0] APB_IR = 8'h0c;
	localparam int CTRL_RUN_BIT = 0;
	localparam logic CTRL_RUN_RESET = 1'b1;

	// ****************************************************************
	// carriers
	// ****************************************************************
	typedef struct packed {
		logic [7:0] op_addr;
		logic dest_we;
		logic [7:0] dest_addr;
		logic [7:0] result;
		logic aff_z;
		logic aff_dc;
		logic aff_c;
		logic carry_raw;
		logic dcarry_raw;
		logic subtract;
		logic jump;
	} ics_exec_t;

	typedef struct packed {
		logic rd;
		logic [7:0] raddr;
		logic we;
		logic [7:0] waddr;
		logic [7:0] wdata;
	} ics_dmem_t;

endpackage

// ---- testbench/ics_mem_model.sv ----
// partner model: program memory and data memory of the core
module ics_mem_model #(
	parameter int PC_W = 13,
	parameter int IW = 14
) (
	input wire logic clk,
	input wire logic [PC_W-1:0] pm_addr,
	output logic [IW-1:0] pm_rdata,
	input wire ics_pkg::ics_dmem_t dm,
	output logic [7:0] dm_rdata
);
	timeunit 1ns;
	timeprecision 1ps;
	import ics_pkg::*;
	logic [7:0] dmem [256];
	logic [7:0] last_q = 8'h00;
	function automatic logic [IW-1:0] word(input logic [PC_W-1:0] a);
		return IW'(a * 5 + 3);
	endfunction
	// rom answers at once; the design samples it late in the cycle
	assign pm_rdata = word(pm_addr);
	// an idle read port shows the inverse of the last byte, never a held value
	assign dm_rdata = dm.rd ? dmem[dm.raddr] : ~last_q;
	initial begin
		for (int i = 0; i < 256; i++) begin
			dmem[i] = 8'(i) ^ 8'h5a;
		end
	end
	always @(posedge clk) begin
		if (dm.rd) begin
			last_q <= dmem[dm.raddr];
		end
		if (dm.we) begin
			dmem[dm.waddr] <= dm.wdata;
		end
	end
endmodule

// ---- testbench/tb_instruction_cycle_and_status.sv ----
// self-checking testbench of the instruction cycle and status block
module tb_instruction_cycle_and_status;
	timeunit 1ns;
	timeprecision 1ps;
	import ics_pkg::*;
	logic clk = 1'b0;
	logic ce = 1'b1;
	logic resetn = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rnd = 32'hcd85;
	logic pready, pslverr, ir_valid, rv = 1'b0;
	logic [12:0] pm_addr, pa = 13'h1fff, jmp_t = 13'h0155;
	logic [13:0] pm_rdata, ir;
	logic [3:0] phase_oh, p, pp = 4'h8, ev = 4'h0;
	ics_exec_t ex = '0;
	ics_exec_t xv;
	logic [7:0] r_exp;
	ics_dmem_t dm;
	logic [7:0] dm_rdata, operand, status, ra, st, r;
	logic [64:0] aq[$];
	logic [64:0] ae;
	logic [15:0] wq[$];
	int n_fail = 0, cmp_count = 0, jcnt = 0;

	always #5 clk = ~clk;

	ics_core_timing u_ics_core_timing (.clk(clk), .resetn(resetn), .ce(ce), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .pm_addr(pm_addr), .pm_rdata(pm_rdata), .ir(ir),
		.ir_valid(ir_valid), .phase_oh(phase_oh), .ex(ex), .jump_target(jmp_t), .dm(dm),
		.dm_rdata(dm_rdata), .operand(operand), .status(status), .timeout_set(ev[3]),
		.timeout_clr(ev[2]), .pwrdn_set(ev[1]), .pwrdn_clr(ev[0]));
	ics_mem_model u_ics_mem_model (.clk(clk), .pm_addr(pm_addr), .pm_rdata(pm_rdata), .dm(dm),
		.dm_rdata(dm_rdata));

	// ********
	// helpers
	// ********
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		cmp_count++;
		if (g !== e) begin
			n_fail++;
			$display("mismatch at %0t: got %h want %h", $time, g, e);
		end
	endtask
	task automatic finish_test();
		$display("fails %0d compares %0d", n_fail, cmp_count);
		if (n_fail == 0 && cmp_count > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction
	function automatic ics_exec_t mk(input logic [7:0] da, r, input logic [4:0] f,
		input logic sub, j);
		return '{8'h21, da != 8'h00, da, r, f[4], f[3], f[2], f[1], f[0], sub, j};
	endfunction
	// e holds {error, data mask, masked data}
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic [64:0] e);
		@(posedge clk);
		aq.push_back(e);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1) begin
			@(posedge clk);
		end
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// returns at the edge that enters phase one
	task automatic bnd();
		@(posedge clk);
		for (int i = 0; i < 9 && phase_oh !== 4'h8; i++) begin
			@(posedge clk);
		end
	endtask
	task automatic ins(input ics_exec_t v, input logic [7:0] e);
		bnd();
		if (v.dest_we && v.dest_addr != STATUS_ADDR_BANK0 && v.dest_addr != STATUS_ADDR_BANK1) begin
			wq.push_back({v.dest_addr, v.result});
		end
		if (v.jump) begin
			jcnt = 2;
		end
		ex <= v;
		bnd();
		ex <= '0;
		chk(32'(status), 32'(e));
		st = e;
	endtask
	task automatic pulse(input logic [3:0] v, input logic [7:0] e);
		@(posedge clk);
		ev <= v;
		@(posedge clk);
		ev <= 4'h0;
		@(posedge clk);
		chk(32'(status), 32'(e));
		st = e;
	endtask

	// ********
	// output watcher
	// ********
	always @(posedge clk) begin
		if (resetn) begin
			if (phase_oh !== pp) begin
				chk(32'(phase_oh), 32'({pp[2:0], pp[3]}));
				if (phase_oh === 4'h1) begin
					chk(32'(pm_addr), 32'(jcnt == 1 ? jmp_t : 13'(pa + 1)));
					chk(32'(ir_valid), 32'(jcnt != 1 && pa != 13'h1fff));
					if (ir_valid === 1'b1) begin
						chk(32'(ir), 32'(u_ics_mem_model.word(pa)));
					end
					pa = pm_addr;
					jcnt = jcnt > 0 ? jcnt - 1 : 0;
				end
				if (phase_oh === 4'h4 && rv) begin
					r_exp = u_ics_mem_model.dmem[ra];
					if (ra == STATUS_ADDR_BANK0 || ra == STATUS_ADDR_BANK1) begin
						r_exp = st;
					end
					chk(32'(operand), 32'(r_exp));
					rv = 1'b0;
				end
			end
			if (dm.rd === 1'b1) begin
				chk(32'(phase_oh), 32'h2);
				ra = dm.raddr;
				rv = 1'b1;
			end
			if (dm.we === 1'b1) begin
				chk(32'(phase_oh), 32'h8);
				chk(32'(wq.size() > 0), 32'h1);
				chk(32'({dm.waddr, dm.wdata}), 32'(wq.pop_front()));
			end
			if (psel && penable && pready === 1'b1) begin
				ae = aq.pop_front();
				chk(prdata & ae[63:32], ae[31:0]);
				chk(32'(pslverr), 32'(ae[64]));
			end
		end
		pp = phase_oh;
	end

	// ********
	// main sequence
	// ********
	initial begin
		repeat (6) @(posedge clk);
		resetn <= 1'b1;
		chk(32'(status), 32'(STATUS_RESET));
		apb(1'b0, APB_CTRL, 32'h0, {1'b0, 32'h1, 32'h1});
		apb(1'b0, 8'h10, 32'h0, {1'b1, 32'hffffffff, 32'h0});
		apb(1'b1, APB_PC, 32'h55, {1'b0, 32'h0, 32'h0});
		repeat (2) ins(mk(8'h00, 8'h00, 5'h00, 1'b0, 1'b0), STATUS_RESET);
		ins(mk(STATUS_ADDR_BANK0, 8'h27, 5'h00, 1'b0, 1'b0), 8'h3f);
		ins(mk(STATUS_ADDR_BANK1, 8'h00, 5'h00, 1'b0, 1'b0), 8'h18);
		pulse(4'h4, 8'h08);
		pulse(4'h1, 8'h00);
		ins(mk(STATUS_ADDR_BANK0, 8'h3f, 5'h00, 1'b0, 1'b0), 8'h27);
		pulse(4'he, 8'h3f);
		ins(mk(STATUS_ADDR_BANK0, 8'h00, 5'h10, 1'b0, 1'b0), 8'h1f);
		ins(mk(STATUS_ADDR_BANK0, 8'h20, 5'h1f, 1'b0, 1'b0), 8'h3b);
		apb(1'b0, APB_STATUS, 32'h0, {1'b0, 32'h1ff, 32'h13b});
		rnd = lfsr(rnd);
		ins(mk(8'h30, rnd[7:0] | 8'h01, 5'h1e, 1'b1, 1'b0), 8'h3a);
		for (int i = 0; i < 3; i++) begin
			rnd = lfsr(rnd);
			r = i == 0 ? 8'h00 : rnd[7:0] | 8'h80;
			ins(mk(8'h40 + 8'(i), r, 5'h10, 1'b0, 1'b0), {st[7:3], r == 8'h00, st[1:0]});
		end
		ins(mk(8'h00, 8'h00, 5'h00, 1'b0, 1'b1), st);
		// an operand at the mirrored status address comes from the status register
		xv = mk(8'h00, 8'h00, 5'h00, 1'b0, 1'b0);
		xv.op_addr = STATUS_ADDR_BANK1;
		ins(xv, st);
		// stopping the run must freeze the phase wherever it stands
		apb(1'b1, APB_CTRL, 32'h0, {1'b0, 32'h0, 32'h0});
		@(posedge clk);
		p = phase_oh;
		repeat (4) begin
			@(posedge clk);
			chk(32'(phase_oh), 32'(p));
		end
		apb(1'b1, APB_CTRL, 32'h1, {1'b0, 32'h0, 32'h0});
		// a low enable must hold the phase as well
		ce <= 1'b0;
		@(posedge clk);
		p = phase_oh;
		repeat (4) begin
			@(posedge clk);
			chk(32'(phase_oh), 32'(p));
		end
		ce <= 1'b1;
		repeat (2) ins(mk(8'h00, 8'h00, 5'h00, 1'b0, 1'b0), st);
		finish_test();
	end

	initial begin
		#100000;
		n_fail++;
		finish_test();
	end
endmodule
